// ===== hdl/ocs_pkg.sv
/*
  Shared constants for the offset calibration sequencer: register map,
  field positions, reset values and timing counts.
  Assumes a 40 MHz single clock on both ends.
*/
package ocs_pkg;
  localparam logic [7:0] REG_GAIN_R      = 8'h06;
  localparam logic [7:0] REG_GAIN_G      = 8'h07;
  localparam logic [7:0] REG_GAIN_B      = 8'h08;
  localparam logic [7:0] REG_MAN_OFS_R   = 8'h09;
  localparam logic [7:0] REG_MAN_OFS_G   = 8'h0A;
  localparam logic [7:0] REG_MAN_OFS_B   = 8'h0B;
  localparam logic [7:0] REG_CAL_CTRL    = 8'h0C;
  localparam logic [7:0] REG_INIT_TRIM   = 8'h13;
  localparam logic [7:0] INIT_STEP1      = 8'h06;
  localparam logic [7:0] INIT_STEP2      = 8'h00;
  localparam int         CAL_START_BIT   = 0;
  localparam int         CAL_MODE_BIT    = 1;
  localparam int         CAL_SHORT_BIT   = 2;
  localparam int         MAN_EN_BIT      = 7;
  localparam int         OFS_W           = 7;
  localparam logic [6:0] OFS_MID         = 7'h40;
  localparam logic [7:0] GAIN_RESET      = 8'h40;
  localparam logic [7:0] GAIN_MIN        = 8'h40;
  localparam logic [7:0] GAIN_MAX        = 8'h58;
  localparam int         CLK_MHZ         = 40;
  localparam int         CAL_TIME_NS     = 3000;
  // longest time: rounds down
  localparam int         CAL_CYCLES      = CAL_TIME_NS * CLK_MHZ / 1000;
  localparam int         STEP_CYCLES     = CAL_CYCLES / OFS_W;
  // host-side register map
  localparam logic [1:0] HREG_CMD        = 2'h0;
  localparam logic [1:0] HREG_STATUS     = 2'h1;
  localparam logic [1:0] HREG_IRQ_STAT   = 2'h2;
  localparam logic [1:0] HREG_IRQ_MASK   = 2'h3;
  localparam int         CMD_INIT_BIT    = 0;
  localparam int         CMD_CAL_BIT     = 1;
  localparam int         CMD_CALMODE_BIT = 2;
  localparam int         IRQ_INIT_BIT    = 0;
  localparam int         IRQ_CAL_BIT     = 1;
endpackage

// ===== hdl/ocs_link_if.sv
/*
  Link between host controller and equalizer: a simple parallel register
  write/read port standing in for the serial bus, plus the enable pin.
  Assumes both ends share clock_in.
*/
`timescale 1ns/100ps
`default_nettype none
interface ocs_link_if;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic       wr;
  logic       rd;
  logic [7:0] rdata;
  logic       enable;
  modport device (input addr, wdata, wr, rd, enable, output rdata);
  modport host   (output addr, wdata, wr, rd, enable, input rdata);
endinterface
`default_nettype wire

// ===== hdl/ocs_device.sv
/*
  Equalizer end: control registers, offset calibration sequencer with
  three parallel successive-approximation searches, output enable.
  Assumes comparator inputs are synchronous and settle within a step.
*/
// Behaviour
// R01: host writes 0x06 then 0x00 to 0x13
// R02: writing one to bit 0 starts calibration
// R03: device clears start bit when finished
// R04: calibration shorts inputs, compares output to reference
// R05: SAR picks offset code from comparator result
// R06: calibration finishes within about three microseconds
// R07: offset undefined until first calibration completes
// R08: host calibrates after filter and gain writes
// R09: enable low tri-states all three video outputs
// R10: host programs gain 0x40 up to 0x58; host here writes no gain register, device stores any value
// R11: bit 1 keeps external inputs during calibration
// R12: manual bit selects seven-bit manual offset field
// R13: 7-bit SAR, MSB first, channels in parallel
`timescale 1ns/100ps
`default_nettype none
module ocs_device #(
  parameter int STEP_CYCLES = ocs_pkg::STEP_CYCLES
) (
  input  wire logic       clock_in,     // 40 MHz clock
  input  wire logic       resetn_in,    // async reset, active low
  ocs_link_if.device      link,         // register port and enable
  input  wire logic [2:0] cmp_high_in,  // per channel: output above ref
  output logic [6:0]      dac_red_out,  // red offset converter code
  output logic [6:0]      dac_green_out,// green offset converter code
  output logic [6:0]      dac_blue_out, // blue offset converter code
  output logic            short_out,    // inputs shorted internally
  output logic            cal_busy_out, // calibration running
  output logic            ofs_valid_out,// offset defined
  output logic [2:0]      vid_oe_n_out  // video output enables, low drives
);
  typedef enum logic [1:0] {OCS_IDLE, OCS_STEP, OCS_DONE} ocs_state_t;

  ocs_state_t state;
  logic [7:0] man_ofs [3];
  logic [7:0] gain [3];
  logic [2:0] cal_ctrl;
  logic [7:0] init_trim;
  logic [6:0] sar [3];
  logic [6:0] trial;
  logic [15:0] step_cnt;
  logic [2:0] bit_idx;
  logic       start_req;
  logic       cal_clear;

  function automatic logic [6:0] pick(input logic [7:0] man,
                                      input logic [6:0] cal);
    pick = man[ocs_pkg::MAN_EN_BIT] ? man[6:0] : cal;  // R12
  endfunction

  assign start_req = link.wr && link.addr == ocs_pkg::REG_CAL_CTRL &&
                     link.wdata[ocs_pkg::CAL_START_BIT];  // R02
  assign cal_clear = (state == OCS_DONE);

  always_ff @(posedge clock_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      cal_ctrl  <= 3'h0;
      init_trim <= 8'h00;
      for (int i = 0; i < 3; i++)
      begin
        man_ofs[i] <= 8'h00;
        gain[i]    <= ocs_pkg::GAIN_RESET;
      end
    end
    else
    begin
      if (link.wr)
      begin
        case (link.addr)
          ocs_pkg::REG_CAL_CTRL:  cal_ctrl <= link.wdata[2:0];
          ocs_pkg::REG_INIT_TRIM: init_trim <= link.wdata;
          ocs_pkg::REG_MAN_OFS_R: man_ofs[0] <= link.wdata;
          ocs_pkg::REG_MAN_OFS_G: man_ofs[1] <= link.wdata;
          ocs_pkg::REG_MAN_OFS_B: man_ofs[2] <= link.wdata;
          ocs_pkg::REG_GAIN_R:    gain[0] <= link.wdata;
          ocs_pkg::REG_GAIN_G:    gain[1] <= link.wdata;
          ocs_pkg::REG_GAIN_B:    gain[2] <= link.wdata;
          default:                ;
        endcase
      end
      // a fresh start in the finishing cycle wins over the clear
      if (cal_clear && !start_req)
        cal_ctrl[ocs_pkg::CAL_START_BIT] <= 1'b0;  // R03
    end
  end

  always_ff @(posedge clock_in or negedge resetn_in)
  begin
    if (!resetn_in)
      link.rdata <= 8'h00;
    else if (link.rd)
    begin
      case (link.addr)
        ocs_pkg::REG_CAL_CTRL:  link.rdata <= {5'h00, cal_ctrl};
        ocs_pkg::REG_INIT_TRIM: link.rdata <= init_trim;
        ocs_pkg::REG_MAN_OFS_R: link.rdata <= man_ofs[0];
        ocs_pkg::REG_MAN_OFS_G: link.rdata <= man_ofs[1];
        ocs_pkg::REG_MAN_OFS_B: link.rdata <= man_ofs[2];
        ocs_pkg::REG_GAIN_R:    link.rdata <= gain[0];
        ocs_pkg::REG_GAIN_G:    link.rdata <= gain[1];
        ocs_pkg::REG_GAIN_B:    link.rdata <= gain[2];
        default:                link.rdata <= 8'h00;
      endcase
    end
  end

  // 7 steps of STEP_CYCLES fit inside the 3 us budget
  always_ff @(posedge clock_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      state    <= OCS_IDLE;
      step_cnt <= 16'h0000;
      bit_idx  <= 3'h0;
      trial    <= 7'h00;
      for (int i = 0; i < 3; i++)
        sar[i] <= ocs_pkg::OFS_MID;
    end
    else
    begin
      case (state)
        // a start in the finishing cycle keeps its bit set, so it must run
        OCS_IDLE,
        OCS_DONE:
          if (start_req)
          begin
            state    <= OCS_STEP;
            bit_idx  <= 3'h6;
            trial    <= 7'h40;
            step_cnt <= 16'h0000;
            for (int i = 0; i < 3; i++)
              sar[i] <= ocs_pkg::OFS_MID;  // R13
          end
          else
            state <= OCS_IDLE;
        OCS_STEP:
          if (step_cnt == 16'(STEP_CYCLES - 1))  // R06
          begin
            step_cnt <= 16'h0000;
            for (int i = 0; i < 3; i++)
            begin
              // output above reference: drop the trial bit  R05
              if (cmp_high_in[i])
                sar[i] <= (sar[i] & ~trial) | (trial >> 1);
              else
                sar[i] <= sar[i] | (trial >> 1);
            end
            trial <= trial >> 1;  // R13
            if (bit_idx == 3'h0)
              state <= OCS_DONE;
            else
              bit_idx <= bit_idx - 3'h1;
          end
          else
            step_cnt <= step_cnt + 16'h0001;
        default:
          state <= OCS_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      dac_red_out   <= ocs_pkg::OFS_MID;
      dac_green_out <= ocs_pkg::OFS_MID;
      dac_blue_out  <= ocs_pkg::OFS_MID;
      short_out     <= 1'b0;
      cal_busy_out  <= 1'b0;
      ofs_valid_out <= 1'b0;
      vid_oe_n_out  <= 3'b111;
    end
    else
    begin
      dac_red_out   <= pick(man_ofs[0], sar[0]);
      dac_green_out <= pick(man_ofs[1], sar[1]);
      dac_blue_out  <= pick(man_ofs[2], sar[2]);
      // short bit forces it regardless of mode  R04 R11
      short_out     <= cal_ctrl[ocs_pkg::CAL_SHORT_BIT] ||
                       (state == OCS_STEP &&
                        !cal_ctrl[ocs_pkg::CAL_MODE_BIT]);
      cal_busy_out  <= (state == OCS_STEP);
      if (cal_clear)
        ofs_valid_out <= 1'b1;  // R07
      vid_oe_n_out  <= {3{!link.enable}};  // R09
    end
  end
endmodule
`default_nettype wire

// ===== hdl/ocs_host.sv
/*
  Host controller end: runs the init sequence and calibrations on
  command, polls the start bit, reports status and interrupts.
  Assumes the device answers reads one cycle after the strobe.
*/
`timescale 1ns/100ps
`default_nettype none
module ocs_host (
  input  wire logic       clock_in,  // 40 MHz clock
  input  wire logic       resetn_in, // async reset, active low
  ocs_link_if.host        link,      // device register port
  input  wire logic [1:0] addr_in,   // register address
  input  wire logic [7:0] wdata_in,  // write data
  input  wire logic       wr_in,     // write strobe
  input  wire logic       rd_in,     // read strobe
  input  wire logic       enable_in, // drive device enable
  output logic [7:0]      rdata_out, // read data, one cycle later
  output logic            irq_out    // level interrupt
);
  typedef enum logic [2:0] {
    OCH_IDLE, OCH_INIT2, OCH_CALW, OCH_POLL, OCH_WAIT
  } och_state_t;

  och_state_t state;
  logic [1:0] irq_stat;
  logic [1:0] irq_mask;
  logic       cal_mode;
  logic       ev_init;
  logic       ev_cal;
  logic       cmd_init;
  logic       cmd_cal;
  logic       stat_rd;

  assign cmd_init = wr_in && addr_in == ocs_pkg::HREG_CMD &&
                    wdata_in[ocs_pkg::CMD_INIT_BIT];
  assign cmd_cal  = wr_in && addr_in == ocs_pkg::HREG_CMD &&
                    wdata_in[ocs_pkg::CMD_CAL_BIT];
  assign stat_rd  = rd_in && addr_in == ocs_pkg::HREG_IRQ_STAT;

  always_ff @(posedge clock_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      state       <= OCH_IDLE;
      link.addr   <= 8'h00;
      link.wdata  <= 8'h00;
      link.wr     <= 1'b0;
      link.rd     <= 1'b0;
      ev_init     <= 1'b0;
      ev_cal      <= 1'b0;
      cal_mode    <= 1'b0;
    end
    else
    begin
      link.wr <= 1'b0;
      link.rd <= 1'b0;
      ev_init <= 1'b0;
      ev_cal  <= 1'b0;
      case (state)
        OCH_IDLE:
          if (cmd_init)
          begin
            link.addr  <= ocs_pkg::REG_INIT_TRIM;
            link.wdata <= ocs_pkg::INIT_STEP1;  // R01
            link.wr    <= 1'b1;
            state      <= OCH_INIT2;
          end
          else if (cmd_cal)
          begin
            cal_mode <= wdata_in[ocs_pkg::CMD_CALMODE_BIT];
            state    <= OCH_CALW;
          end
        OCH_INIT2:
        begin
          link.addr  <= ocs_pkg::REG_INIT_TRIM;
          link.wdata <= ocs_pkg::INIT_STEP2;  // R01
          link.wr    <= 1'b1;
          ev_init    <= 1'b1;
          state      <= OCH_IDLE;
        end
        OCH_CALW:
        begin
          link.addr  <= ocs_pkg::REG_CAL_CTRL;
          link.wdata <= {6'h00, cal_mode, 1'b1};  // R02 R11
          link.wr    <= 1'b1;
          state      <= OCH_POLL;
        end
        OCH_POLL:
        begin
          link.rd <= 1'b1;
          state   <= OCH_WAIT;
        end
        OCH_WAIT:
          // rdata valid now; keep polling until start bit drops  R03
          if (!link.rd)
          begin
            if (link.rdata[ocs_pkg::CAL_START_BIT])
              state <= OCH_POLL;
            else
            begin
              ev_cal <= 1'b1;
              state  <= OCH_IDLE;
            end
          end
        default:
          state <= OCH_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock_in or negedge resetn_in)
  begin
    if (!resetn_in)
      link.enable <= 1'b0;
    else
      link.enable <= enable_in;
  end

  always_ff @(posedge clock_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      irq_stat <= 2'h0;
      irq_mask <= 2'h0;
    end
    else
    begin
      if (wr_in && addr_in == ocs_pkg::HREG_IRQ_MASK)
        irq_mask <= wdata_in[1:0];
      // new events win over the read clear
      irq_stat <= (stat_rd ? 2'h0 : irq_stat) | {ev_cal, ev_init};
    end
  end

  always_ff @(posedge clock_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      rdata_out <= 8'h00;
      irq_out   <= 1'b0;
    end
    else
    begin
      irq_out <= |(irq_stat & irq_mask);
      if (rd_in)
      begin
        case (addr_in)
          ocs_pkg::HREG_CMD:      rdata_out <= {5'h00, cal_mode, 2'h0};
          ocs_pkg::HREG_STATUS:   rdata_out <= {7'h00, state != OCH_IDLE};
          ocs_pkg::HREG_IRQ_STAT: rdata_out <= {6'h00, irq_stat};
          ocs_pkg::HREG_IRQ_MASK: rdata_out <= {6'h00, irq_mask};
          default:                rdata_out <= 8'h00;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// ===== bench/ocs_asserts.sv
/* Checker for the link between host and device and the device outputs.
   Assumes tb instantiates it beside the link, on the same clock. */
`timescale 1ns/100ps
`default_nettype none
module ocs_asserts #(
  parameter int STEP_CYCLES = ocs_pkg::STEP_CYCLES
) (
  input wire logic       clock_in,      // clock
  input wire logic       resetn_in,     // async reset, active low
  input wire logic [7:0] addr,          // link address
  input wire logic [7:0] wdata,         // link write data
  input wire logic       wr,            // link write strobe
  input wire logic       enable,        // device enable
  input wire logic       short_out,     // inputs shorted
  input wire logic       cal_busy_out,  // calibration running
  input wire logic       ofs_valid_out, // offset defined
  input wire logic [2:0] vid_oe_n_out   // video enables, low drives
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!resetn_in);
  // start only counts from idle; a start while running is ignored
  wire cal_wr = wr && addr == ocs_pkg::REG_CAL_CTRL &&
                wdata[ocs_pkg::CAL_START_BIT] && !cal_busy_out;
  a_init_order: assert property (wr && addr == ocs_pkg::REG_INIT_TRIM
    && wdata == ocs_pkg::INIT_STEP1 |=> wr
    && addr == ocs_pkg::REG_INIT_TRIM && wdata == ocs_pkg::INIT_STEP2)
    else $error("init order");
  a_start_busy: assert property (cal_wr |-> ##2 cal_busy_out)
    else $error("start did not begin calibration");
  a_short_mode: assert property (cal_wr && wdata[2:1] == 2'h0
    |-> ##2 short_out) else $error("inputs not shorted");
  a_keep_inputs: assert property (cal_wr && wdata[2:1] == 2'h1
    |-> ##2 !short_out [*8]) else $error("inputs shorted in mode one");
  a_short_in_cal: assert property (short_out |-> cal_busy_out)
    else $error("short outside calibration");
  a_cal_length: assert property ($rose(cal_busy_out)
    |-> cal_busy_out [*8] ##[1:40] !cal_busy_out)
    else $error("calibration length wrong");
  // busy run length: checks the time budget and the exact step count
  logic [15:0] busy_cnt;
  always_ff @(posedge clock_in or negedge resetn_in)
  begin
    if (!resetn_in)
      busy_cnt <= 16'h0000;
    else if (cal_busy_out)
      busy_cnt <= busy_cnt + 16'h0001;
    else
      busy_cnt <= 16'h0000;
  end
  a_cal_budget: assert property (cal_busy_out
    |-> busy_cnt < 16'(ocs_pkg::CAL_CYCLES))
    else $error("calibration over time budget");
  a_cal_steps: assert property ($fell(cal_busy_out)
    |-> busy_cnt == 16'(ocs_pkg::OFS_W * STEP_CYCLES))
    else $error("calibration step count wrong");
  a_valid_after: assert property ($fell(cal_busy_out)
    |-> ##[0:2] ofs_valid_out) else $error("offset not valid after cal");
  a_valid_hold: assert property (ofs_valid_out |=> ofs_valid_out)
    else $error("offset valid dropped");
  a_oe_off: assert property (!enable |=> vid_oe_n_out == 3'h7)
    else $error("outputs driven while disabled");
  a_oe_on: assert property (enable |=> vid_oe_n_out == 3'h0)
    else $error("outputs released while enabled");
  c_mode_one: cover property (cal_wr && wdata[1]);
  c_cal_done: cover property ($fell(cal_busy_out));
  c_enable: cover property (!enable ##1 enable);
endmodule
`default_nettype wire

// ===== bench/tb.sv
/* Self-checking bench: host and device joined by the link, random
   calibration targets, interrupt mask and enable checks.
   Assumes design files and checker are compiled before it. */
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic       clock_in = 1'b0;
  logic       resetn_in = 1'b0;
  logic [1:0] addr = 2'h0;
  logic [7:0] wdata = 8'h00;
  logic       wr = 1'b0;
  logic       rd = 1'b0;
  logic       en = 1'b1;
  logic [2:0] cmp = 3'h0;
  logic [7:0] rdata;
  logic       irq;
  logic [6:0] dac [3];
  logic       short_o;
  logic       busy;
  logic       valid;
  logic [2:0] oe_n;
  logic [6:0] tgt [3] = '{7'h00, 7'h00, 7'h00};
  logic [7:0] d;
  int         bad_count = 0;
  int         compares = 0;
  always #12.5 clock_in = ~clock_in;
  // comparator stand-in: output above reference when code exceeds target
  always @(posedge clock_in)
    cmp <= {dac[2] > tgt[2], dac[1] > tgt[1], dac[0] > tgt[0]};
  ocs_link_if link ();
  ocs_device #(.STEP_CYCLES(4)) ocs_device_i (.clock_in(clock_in),
    .resetn_in(resetn_in), .link(link), .cmp_high_in(cmp),
    .dac_red_out(dac[0]), .dac_green_out(dac[1]), .dac_blue_out(dac[2]),
    .short_out(short_o), .cal_busy_out(busy), .ofs_valid_out(valid),
    .vid_oe_n_out(oe_n));
  ocs_host ocs_host_i (.clock_in(clock_in), .resetn_in(resetn_in),
    .link(link), .addr_in(addr), .wdata_in(wdata), .wr_in(wr),
    .rd_in(rd), .enable_in(en), .rdata_out(rdata), .irq_out(irq));
  ocs_asserts #(.STEP_CYCLES(4)) ocs_asserts_i (.clock_in(clock_in),
    .resetn_in(resetn_in),
    .addr(link.addr), .wdata(link.wdata), .wr(link.wr),
    .enable(link.enable), .short_out(short_o), .cal_busy_out(busy),
    .ofs_valid_out(valid), .vid_oe_n_out(oe_n));
  task automatic summarize();
    if (bad_count == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input string s, input logic [7:0] e,
                     input logic [7:0] g);
    compares++;
    if (g !== e)
    begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic hwr(input logic [1:0] a, input logic [7:0] v);
    @(posedge clock_in);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clock_in);
    wr <= 1'b0;
  endtask
  task automatic hrd(input logic [1:0] a, output logic [7:0] v);
    @(posedge clock_in);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock_in);
    rd <= 1'b0;
    // data stands in the cycle after the strobe; take it at its edge
    @(posedge clock_in);
    v = rdata;
  endtask
  // bounded poll of the host busy flag; a hang ends the run
  task automatic wait_idle();
    for (int i = 0; i < 300; i++)
    begin
      hrd(2'h1, d);
      if (d[0] === 1'b0)
        return;
    end
    chk("idle_wait", 8'h00, d);
    summarize();
  endtask
  initial
  begin
    void'($urandom(32'h2b7b42c9));
    repeat (4) @(posedge clock_in);
    resetn_in <= 1'b1;
    chk("ofs_valid", 8'h00, {7'h0, valid});
    hwr(2'h0, 8'h01);
    wait_idle();
    hrd(2'h2, d);
    chk("irq_stat_init", 8'h01, d);
    for (int k = 0; k < 6; k++)
    begin
      // first two rounds pin the code range ends
      foreach (tgt[c])
        tgt[c] = k == 0 ? 7'h00 : k == 1 ? 7'h7F : 7'($urandom);
      hwr(2'h3, {6'h0, k[0], 1'b0});
      hwr(2'h0, {5'h0, k[2], 2'h2});
      wait_idle();
      // irq output lags the sticky status by one register
      @(posedge clock_in);
      chk("irq_level", {7'h0, k[0]}, {7'h0, irq});
      hrd(2'h2, d);
      chk("irq_stat_cal", 8'h02, d);
      repeat (2) @(posedge clock_in);
      chk("irq_cleared", 8'h00, {7'h0, irq});
      foreach (tgt[c])
        chk("dac_code", {1'b0, tgt[c]}, {1'b0, dac[c]});
      chk("ofs_valid", 8'h01, {7'h0, valid});
    end
    en <= 1'b0;
    repeat (3) @(posedge clock_in);
    chk("oe_n_off", 8'h07, {5'h0, oe_n});
    en <= 1'b1;
    repeat (3) @(posedge clock_in);
    chk("oe_n_on", 8'h00, {5'h0, oe_n});
    summarize();
  end
endmodule
`default_nettype wire
